// ===== design/mss_pkg.sv
package mss_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LVL_W  = 10;
    localparam int TIM_W  = 16;
    localparam int CUR_W  = 16;
    localparam int AIN_W  = 12;

    // Levels are in tenths of a percent of full scale
    localparam logic [LVL_W-1:0] LVL_FULL = 10'h3E8;

    localparam logic [ADDR_W-1:0] A_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] A_BEGIN = 8'h04;
    localparam logic [ADDR_W-1:0] A_END   = 8'h08;
    localparam logic [ADDR_W-1:0] A_DTIME = 8'h0C;
    localparam logic [ADDR_W-1:0] A_UTS   = 8'h10;
    localparam logic [ADDR_W-1:0] A_FLA   = 8'h14;
    localparam logic [ADDR_W-1:0] A_FBT   = 8'h18;
    localparam logic [ADDR_W-1:0] A_AOFS  = 8'h1C;
    localparam logic [ADDR_W-1:0] A_ASPAN = 8'h20;
    localparam logic [ADDR_W-1:0] A_STAT  = 8'h24;

    // Control and status register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FBEN_BIT = 2;
    localparam int STAT_TRIP_BIT = 8;
    localparam int STAT_STATE_LSB = 0;

    localparam logic [1:0] MODE_VDEC  = 2'h0;
    localparam logic [1:0] MODE_TDEC  = 2'h1;
    localparam logic [1:0] MODE_WYE   = 2'h2;
    localparam logic [1:0] MODE_PHASE = 2'h3;

    localparam logic [LVL_W-1:0] RST_BEGIN = 10'h15E;
    localparam logic [LVL_W-1:0] RST_END   = 10'h064;
    localparam logic [TIM_W-1:0] RST_DTIME = 16'h7530;
    localparam logic [TIM_W-1:0] RST_UTS   = 16'h2710;
    localparam logic [CUR_W-1:0] RST_FLA   = 16'h0064;
    localparam logic [TIM_W-1:0] RST_FBT   = 16'h07D0;
    localparam logic [AIN_W-1:0] RST_AOFS  = 12'h000;
    localparam logic [AIN_W-1:0] RST_ASPAN = 12'hFFF;

    // Early transition thresholds, in percent
    localparam int PCT_CUR = 85;
    localparam int PCT_UTS = 25;
    localparam int PCT_ALL = 100;

    localparam int CLK_HZ      = 50_000_000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_RUN   = 6'b000010,
        ST_DECEL = 6'b000100,
        ST_WYE   = 6'b001000,
        ST_DELTA = 6'b010000,
        ST_PHASE = 6'b100000
    } mss_state_t;
endpackage

// ===== design/mss_seq.sv
`timescale 1ns/1ps
module mss_seq #(
    parameter int TICK_CYC = mss_pkg::TICK_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [mss_pkg::ADDR_W-1:0] addr,
    input  wire logic [mss_pkg::DATA_W-1:0] wr_data,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic      [mss_pkg::DATA_W-1:0] rd_data,
    input  wire logic                       start_cmd,
    input  wire logic                       fault_in,
    input  wire logic [mss_pkg::CUR_W-1:0]  current_meas,
    input  wire logic [mss_pkg::LVL_W-1:0]  torque_meas,
    input  wire logic [mss_pkg::AIN_W-1:0]  analog_in,
    input  wire logic                       delta_closed,
    output logic                            run_relay,
    output logic                            uts_relay,
    output logic                            gate_enable,
    output logic      [mss_pkg::LVL_W-1:0]  firing_level,
    output logic      [mss_pkg::LVL_W-1:0]  torque_ref,
    output logic                            scr_prot_en,
    output logic                            stack_prot_en,
    output logic                            closure_trip
);
    import mss_pkg::*;

    mss_state_t state;
    mss_state_t next_state;

    logic [1:0]       mode;
    logic             fb_en;
    logic [LVL_W-1:0] dec_begin;
    logic [LVL_W-1:0] dec_end;
    logic [TIM_W-1:0] dec_time;
    logic [TIM_W-1:0] uts_time;
    logic [CUR_W-1:0] full_load_current_rating;
    logic [TIM_W-1:0] fb_time;
    logic [AIN_W-1:0] ain_ofs;
    logic [AIN_W-1:0] ain_span;

    logic [31:0]      tick_cnt;
    logic             tick;
    logic [TIM_W-1:0] t_cnt;
    logic [TIM_W-1:0] fb_cnt;
    logic             fb_seen;
    logic [LVL_W-1:0] ramp_start;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] b);
        hit = (a == b);
    endfunction

    wire wr_ctrl  = wr_en && hit(addr, A_CTRL);
    wire wr_stat  = wr_en && hit(addr, A_STAT);
    wire trip_clr = wr_stat && wr_data[STAT_TRIP_BIT];

    assign tick = (tick_cnt == 32'(TICK_CYC - 1));

    // The first decel cycle must already show the level captured at the stop
    wire             enter_decel = (state == ST_RUN) && (next_state == ST_DECEL);
    wire [LVL_W-1:0] cap_level   = (mode == MODE_TDEC) ? torque_meas : dec_begin;
    wire [LVL_W-1:0] ramp_base   = enter_decel ? cap_level : ramp_start;
    wire [TIM_W-1:0] ramp_t      = enter_decel ? '0 : t_cnt;

    // Linear interpolation; a zero decel time ends the ramp at once
    wire [LVL_W-1:0] ramp_diff = (ramp_base > dec_end) ?
                                 LVL_W'(ramp_base - dec_end) : '0;
    wire [31:0] ramp_prod = 32'(ramp_diff) * 32'(ramp_t);
    wire [31:0] ramp_quo  = (dec_time == '0) ? 32'(ramp_diff) :
                            ramp_prod / 32'(dec_time);
    wire [LVL_W-1:0] ramp_val = (ramp_base > dec_end) ?
                                LVL_W'(ramp_base - LVL_W'(ramp_quo)) :
                                dec_end;
    wire ramp_done = (t_cnt >= dec_time);

    // Wye to delta decision
    wire [31:0] cur_x  = 32'(current_meas) * 32'(PCT_ALL);
    wire [31:0] fla_x  = 32'(full_load_current_rating) * 32'(PCT_CUR);
    wire [31:0] t_x    = 32'(t_cnt) * 32'(PCT_ALL);
    wire [31:0] uts_x  = 32'(uts_time) * 32'(PCT_UTS);
    wire early_go = (cur_x < fla_x) && (t_x > uts_x);
    wire force_go = (t_cnt >= uts_time);
    wire to_delta = early_go || force_go;

    // Analog reference scaling, clamped at full output
    wire [AIN_W-1:0] ain_adj = (analog_in > ain_ofs) ?
                               AIN_W'(analog_in - ain_ofs) : '0;
    wire [31:0] ain_prod = 32'(ain_adj) * 32'(LVL_FULL);
    wire [31:0] ain_quo  = (ain_span == '0) ? 32'h0 :
                           ain_prod / 32'(ain_span);
    wire [LVL_W-1:0] phase_lvl = (ain_quo > 32'(LVL_FULL)) ?
                                 LVL_FULL : LVL_W'(ain_quo);

    wire fb_timeout = fb_en && !fb_seen && !delta_closed &&
                      (fb_cnt >= fb_time);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_cmd && !fault_in) begin
                    case (mode)
                        MODE_WYE:   next_state = ST_WYE;
                        MODE_PHASE: next_state = ST_PHASE;
                        default:    next_state = ST_RUN;
                    endcase
                end
            end
            ST_RUN: begin
                if (fault_in) begin
                    next_state = ST_IDLE;
                end else if (!start_cmd) begin
                    next_state = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (fault_in) begin
                    next_state = ST_IDLE;
                end else if (start_cmd) begin
                    next_state = ST_RUN;
                end else if (tick && ramp_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WYE: begin
                // Stop skips decel entirely here
                if (fault_in || !start_cmd) begin
                    next_state = ST_IDLE;
                end else if (to_delta) begin
                    next_state = ST_DELTA;
                end
            end
            ST_DELTA: begin
                if (fault_in || !start_cmd || fb_timeout) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PHASE: begin
                if (fault_in || !start_cmd) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Prescaler restarts with the state, so the first step is a whole tick away
    always_ff @(posedge clk) begin
        if (srst || tick || next_state != state) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // Step timer restarts on every state change
    always_ff @(posedge clk) begin
        if (srst || next_state != state) begin
            t_cnt <= '0;
        end else if (tick && t_cnt != '1) begin
            t_cnt <= t_cnt + 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state != ST_DELTA) begin
            fb_cnt  <= '0;
            fb_seen <= 1'b0;
        end else begin
            if (delta_closed) begin
                fb_seen <= 1'b1;
            end
            if (tick && fb_cnt != '1) begin
                fb_cnt <= fb_cnt + 16'h1;
            end
        end
    end

    // Begin level or live load is frozen at the stop edge
    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_start <= '0;
        end else if (enter_decel) begin
            ramp_start <= cap_level;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode  <= MODE_VDEC;
            fb_en <= 1'b0;
        end else if (wr_ctrl) begin
            mode  <= wr_data[CTRL_MODE_LSB +: 2];
            fb_en <= wr_data[CTRL_FBEN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dec_begin <= RST_BEGIN;
        end else if (wr_en && hit(addr, A_BEGIN)) begin
            dec_begin <= wr_data[LVL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dec_end <= RST_END;
        end else if (wr_en && hit(addr, A_END)) begin
            dec_end <= wr_data[LVL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dec_time <= RST_DTIME;
        end else if (wr_en && hit(addr, A_DTIME)) begin
            dec_time <= wr_data[TIM_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            uts_time <= RST_UTS;
        end else if (wr_en && hit(addr, A_UTS)) begin
            uts_time <= wr_data[TIM_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            full_load_current_rating <= RST_FLA;
        end else if (wr_en && hit(addr, A_FLA)) begin
            full_load_current_rating <= wr_data[CUR_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fb_time <= RST_FBT;
        end else if (wr_en && hit(addr, A_FBT)) begin
            fb_time <= wr_data[TIM_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ain_ofs <= RST_AOFS;
        end else if (wr_en && hit(addr, A_AOFS)) begin
            ain_ofs <= wr_data[AIN_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ain_span <= RST_ASPAN;
        end else if (wr_en && hit(addr, A_ASPAN)) begin
            ain_span <= wr_data[AIN_W-1:0];
        end
    end

    // Timeout sets over a same-cycle clear
    always_ff @(posedge clk) begin
        if (srst) begin
            closure_trip <= 1'b0;
        end else if (state == ST_DELTA && fb_timeout) begin
            closure_trip <= 1'b1;
        end else if (trip_clr) begin
            closure_trip <= 1'b0;
        end
    end

    wire wye_mode = (mode == MODE_WYE);
    wire nx_run = (next_state == ST_RUN) || (next_state == ST_DECEL) ||
                  (next_state == ST_WYE) || (next_state == ST_DELTA) ||
                  (next_state == ST_PHASE);
    wire nx_gate = !wye_mode && ((next_state == ST_RUN) ||
                   (next_state == ST_DECEL) || (next_state == ST_PHASE));
    wire [LVL_W-1:0] nx_fire =
        (next_state == ST_RUN)   ? LVL_FULL :
        (next_state == ST_PHASE) ? phase_lvl :
        (next_state == ST_DECEL && mode == MODE_VDEC) ? ramp_val :
        (next_state == ST_DECEL) ? LVL_FULL : '0;
    wire [LVL_W-1:0] nx_torque =
        (next_state == ST_DECEL && mode == MODE_TDEC) ? ramp_val : '0;

    always_ff @(posedge clk) begin
        if (srst) begin
            run_relay <= 1'b0;
            uts_relay <= 1'b0;
        end else begin
            run_relay <= nx_run;
            uts_relay <= (next_state == ST_DELTA);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gate_enable  <= 1'b0;
            firing_level <= '0;
        end else begin
            gate_enable  <= nx_gate;
            firing_level <= nx_gate ? nx_fire : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            torque_ref <= '0;
        end else begin
            torque_ref <= nx_torque;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            scr_prot_en   <= 1'b1;
            stack_prot_en <= 1'b1;
        end else begin
            scr_prot_en   <= !wye_mode;
            stack_prot_en <= !wye_mode;
        end
    end

    wire [DATA_W-1:0] rd_ctrl = DATA_W'({fb_en, mode});
    wire [DATA_W-1:0] rd_stat = DATA_W'({closure_trip, 2'h0, state});
    wire [DATA_W-1:0] rd_mux =
        hit(addr, A_CTRL)  ? rd_ctrl :
        hit(addr, A_BEGIN) ? DATA_W'(dec_begin) :
        hit(addr, A_END)   ? DATA_W'(dec_end) :
        hit(addr, A_DTIME) ? DATA_W'(dec_time) :
        hit(addr, A_UTS)   ? DATA_W'(uts_time) :
        hit(addr, A_FLA)   ? DATA_W'(full_load_current_rating) :
        hit(addr, A_FBT)   ? DATA_W'(fb_time) :
        hit(addr, A_AOFS)  ? DATA_W'(ain_ofs) :
        hit(addr, A_ASPAN) ? DATA_W'(ain_span) :
        hit(addr, A_STAT)  ? rd_stat : '0;

    always_ff @(posedge clk) begin
        if (srst || !rd_en) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_mux;
        end
    end
endmodule

// ===== bench/mss_seq_sva.sv
`timescale 1ns/1ps
module mss_chk #(
    parameter int TICK_CYC = 8
) (
    input wire logic                       clk,
    input wire logic                       srst,
    input wire logic [mss_pkg::ADDR_W-1:0] addr,
    input wire logic [mss_pkg::DATA_W-1:0] wr_data,
    input wire logic                       wr_en,
    input wire logic                       start_cmd,
    input wire logic                       fault_in,
    input wire logic [mss_pkg::LVL_W-1:0]  torque_meas,
    input wire logic                       delta_closed,
    input wire logic                       run_relay,
    input wire logic                       uts_relay,
    input wire logic                       gate_enable,
    input wire logic [mss_pkg::LVL_W-1:0]  firing_level,
    input wire logic [mss_pkg::LVL_W-1:0]  torque_ref,
    input wire logic                       scr_prot_en,
    input wire logic                       stack_prot_en,
    input wire logic                       closure_trip
);
    import mss_pkg::*;
    logic [1:0]       mode_q;
    logic             fben_q;
    logic [LVL_W-1:0] beg_q;
    wire              ctrl_wr = wr_en && addr == A_CTRL;
    wire              wye     = mode_q == MODE_WYE;
    // Shadow copies: the checker only sees the bus, not the registers
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= MODE_VDEC;
            fben_q <= 1'b0;
            beg_q  <= RST_BEGIN;
        end else begin
            if (ctrl_wr) begin
                mode_q <= wr_data[1:0];
                fben_q <= wr_data[CTRL_FBEN_BIT];
            end
            if (wr_en && addr == A_BEGIN) begin
                beg_q <= wr_data[LVL_W-1:0];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_wye_go;
        wye && $rose(start_cmd) && !fault_in && !run_relay;
    endsequence
    sequence s_stop(logic [1:0] m);
        mode_q == m && run_relay && $fell(start_cmd) && !fault_in;
    endsequence
    AST_WYE_START: assert property (s_wye_go |=> run_relay && !uts_relay)
        else $error("wye start did not raise run relay alone");
    AST_WYE_GATES: assert property (wye [*2] |-> !gate_enable && firing_level == '0)
        else $error("gates active in wye-delta mode");
    AST_WYE_PROT: assert property (wye [*2] |-> !scr_prot_en && !stack_prot_en)
        else $error("thyristor protections left on in wye-delta mode");
    AST_DELTA_PAIR: assert property (wye && uts_relay |-> run_relay)
        else $error("up-to-speed relay without run relay");
    AST_WYE_EXIT: assert property (wye && run_relay && (!start_cmd || fault_in)
        |=> !run_relay && !uts_relay)
        else $error("relays held after stop or fault");
    AST_DELTA_HOLD: assert property (wye && uts_relay && start_cmd && !fault_in
        |=> uts_relay || closure_trip)
        else $error("delta dropped without cause");
    AST_VDEC_BEGIN: assert property (s_stop(MODE_VDEC) |=> firing_level == beg_q)
        else $error("voltage ramp did not start at begin level");
    AST_VDEC_FALL: assert property (mode_q == MODE_VDEC && !start_cmd && gate_enable
        ##1 gate_enable |-> firing_level <= $past(firing_level))
        else $error("voltage rose during deceleration");
    AST_TDEC_CAP: assert property (s_stop(MODE_TDEC) |=> torque_ref == $past(torque_meas))
        else $error("torque ramp did not start at captured load");
    AST_TRIP_CAUSE: assert property ($rose(closure_trip)
        |-> fben_q && !$past(delta_closed) && $past(uts_relay))
        else $error("closure trip without missing feedback");
endmodule

bind mss_seq mss_chk #(.TICK_CYC(TICK_CYC)) chk_u (
    .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .start_cmd(start_cmd), .fault_in(fault_in), .torque_meas(torque_meas),
    .delta_closed(delta_closed), .run_relay(run_relay), .uts_relay(uts_relay),
    .gate_enable(gate_enable), .firing_level(firing_level), .torque_ref(torque_ref),
    .scr_prot_en(scr_prot_en), .stack_prot_en(stack_prot_en), .closure_trip(closure_trip)
);

// ===== bench/mss_plant.sv
`timescale 1ns/1ps
module mss_plant #(
    parameter int CLOSE_CYC = 3
) (
    input  wire logic clk,
    input  wire logic run_relay,
    input  wire logic uts_relay,
    input  wire logic stuck,
    output logic      delta_closed
);
    int wait_cnt;
    // Delta closes once the count reaches CLOSE_CYC with run and up-to-speed relays both on, unless stuck
    always @(posedge clk) begin
        if (!(run_relay && uts_relay)) begin
            wait_cnt <= 0;
            delta_closed <= 1'b0;
        end else if (wait_cnt < CLOSE_CYC) begin
            wait_cnt <= wait_cnt + 1;
        end else begin
            delta_closed <= !stuck;
        end
    end
endmodule

// ===== bench/mss_seq_test.sv
`timescale 1ns/1ps
module mss_seq_test;
    import mss_pkg::*;
    localparam int T = 8;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic              start_cmd = 1'b0;
    logic              fault_in = 1'b0;
    logic              stuck = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] d;
    logic [CUR_W-1:0]  current_meas = 16'h0055;
    logic [LVL_W-1:0]  torque_meas = 10'h258;
    logic [AIN_W-1:0]  analog_in = 12'h300;
    logic              delta_closed, run_relay, uts_relay, gate_enable;
    logic              scr_prot_en, stack_prot_en, closure_trip;
    logic [LVL_W-1:0]  firing_level;
    logic [LVL_W-1:0]  torque_ref;
    int                n_mismatch = 0;
    int                cmp_count = 0;
    int                c;

    mss_seq #(.TICK_CYC(T)) dut_u (
        .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .start_cmd(start_cmd), .fault_in(fault_in),
        .current_meas(current_meas), .torque_meas(torque_meas), .analog_in(analog_in),
        .delta_closed(delta_closed), .run_relay(run_relay), .uts_relay(uts_relay),
        .gate_enable(gate_enable), .firing_level(firing_level), .torque_ref(torque_ref),
        .scr_prot_en(scr_prot_en), .stack_prot_en(stack_prot_en),
        .closure_trip(closure_trip)
    );
    mss_plant #(.CLOSE_CYC(3)) plant_u (.clk(clk), .run_relay(run_relay),
        .uts_relay(uts_relay), .stuck(stuck), .delta_closed(delta_closed));

    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic run(input logic v);
        @(posedge clk) start_cmd <= v;
        step(1);
    endtask
    // Start is taken two edges after the call; count edges up to the delta switch
    task automatic wye_run(input int lo, input int hi);
        run(1'b1);
        chk({run_relay, uts_relay, gate_enable}, 3'h4);
        c = 0;
        while (uts_relay !== 1'b1 && c < 2000) begin
            step(1);
            c++;
        end
        chk(c >= lo && c <= hi, 1);
    endtask
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rchk(A_CTRL, 0);
        rchk(A_BEGIN, RST_BEGIN);
        rchk(A_END, RST_END);
        rchk(A_DTIME, RST_DTIME);
        rchk(A_UTS, RST_UTS);
        rchk(A_FLA, RST_FLA);
        rchk(A_FBT, RST_FBT);
        rchk(A_AOFS, RST_AOFS);
        rchk(A_ASPAN, RST_ASPAN);
        rchk(A_STAT, 1);
        rchk(8'h40, 0);
        wr(A_BEGIN, 10'h190);
        wr(A_END, 10'h0C8);
        wr(A_DTIME, 4);
        run(1'b1);
        step(2);
        run(1'b0);
        chk(firing_level, 10'h190);
        step(2 * T + T / 2);
        chk(firing_level, 10'h12C);
        step(T);
        chk(firing_level, 10'h0FA);
        step(T);
        chk(firing_level, 10'h0C8);
        step(T);
        chk({gate_enable, firing_level}, 0);
        wr(A_CTRL, MODE_TDEC);
        run(1'b1);
        step(2);
        @(posedge clk) start_cmd <= 1'b0;
        @(posedge clk) torque_meas <= 10'h064;
        #1 chk(torque_ref, 10'h258);
        step(2 * T + T / 2);
        chk(torque_ref, 10'h190);
        step(T);
        chk(torque_ref, 10'h12C);
        step(T);
        chk(torque_ref, 10'h0C8);
        step(T);
        chk(torque_ref, 0);
        // Current at exactly 85% must not trigger the early switch
        wr(A_CTRL, MODE_WYE | 4);
        wr(A_UTS, 4);
        wr(A_FBT, 3);
        wye_run(4 * T - 4, 4 * T + 4);
        chk({scr_prot_en, stack_prot_en}, 0);
        step(5 * T);
        chk({run_relay, uts_relay, closure_trip}, 3'h6);
        run(1'b0);
        chk({run_relay, uts_relay}, 0);
        @(posedge clk) current_meas <= 16'h0054;
        wr(A_UTS, 8);
        wye_run(5 * T / 2, 7 * T / 2);
        @(posedge clk) fault_in <= 1'b1;
        step(1);
        chk({run_relay, uts_relay}, 0);
        @(posedge clk) start_cmd <= 1'b0;
        fault_in <= 1'b0;
        stuck <= 1'b1;
        current_meas <= 16'h0055;
        wr(A_UTS, 4);
        wye_run(4 * T - 4, 4 * T + 4);
        step(2 * T);
        chk(closure_trip, 0);
        step(2 * T);
        chk({closure_trip, uts_relay}, 2'h2);
        run(1'b0);
        rd(A_STAT);
        chk(d[STAT_TRIP_BIT], 1);
        wr(A_STAT, 32'h0000_0100);
        rchk(A_STAT, 1);
        wr(A_AOFS, 12'h100);
        wr(A_ASPAN, 12'h400);
        wr(A_CTRL, MODE_PHASE);
        run(1'b1);
        step(1);
        chk({run_relay, gate_enable, scr_prot_en}, 3'h7);
        chk(firing_level, 10'h1F4);
        @(posedge clk) analog_in <= 12'h800;
        step(2);
        chk(firing_level, LVL_FULL);
        @(posedge clk) analog_in <= 12'h100;
        step(2);
        chk(firing_level, 0);
        run(1'b0);
        summarize();
    end
endmodule
